// file: stlc_cfg.svh
// Purpose: Constants of the serial transmit link control block
// Assumes: Included by bare name; definitions only
// Notes: Register offsets are word indexes; byte address is index * 4
`ifndef STLC_CFG_SVH
`define STLC_CFG_SVH
// ----------------------------------------
// Register map
// ----------------------------------------
`define STLC_IDX_CTRL_A 14'h0571
`define STLC_IDX_CTRL_B 14'h0572
`define STLC_IDX_CTRL_C 14'h0578
`define STLC_IDX_STATUS 14'h0579
`define STLC_RST_CTRL_A 8'h14
`define STLC_RST_CTRL_B 8'h00
`define STLC_RST_CTRL_C 8'h00
`define STLC_MASK_CTRL_B 8'hf7
`define STLC_SEL_A 2'h0
`define STLC_SEL_B 2'h1
`define STLC_SEL_C 2'h2
`define STLC_RESP_OKAY 2'h0
`define STLC_RESP_SLVERR 2'h2
// ----------------------------------------
// Field positions
// ----------------------------------------
`define STLC_A_STBY_SEL 7
`define STLC_A_LONG_TPL 5
`define STLC_A_LANE_SYNC 4
`define STLC_A_ILAS_HI 3
`define STLC_A_ILAS_LO 2
`define STLC_A_FRAME_ALIGN_CHAR_INSERT_DIS 1
`define STLC_A_LINK_PD 0
`define STLC_B_SYNC_HI 7
`define STLC_B_SYNC_LO 6
`define STLC_B_SYNC_INV 5
`define STLC_B_SYNC_TYPE 4
`define STLC_C_STANDBY 0
// ----------------------------------------
// Mode codes and control characters
// ----------------------------------------
`define STLC_ILAS_OFF 2'h0
`define STLC_ILAS_LOOP 2'h3
`define STLC_SYNC_FORCE_CGS 2'h2
`define STLC_SYNC_FORCE_DATA 2'h3
`define STLC_ILAS_LAST_MF 2'h3
`define STLC_K28_0 8'h1c
`define STLC_K28_3 8'h7c
`define STLC_K28_4 8'h9c
`define STLC_K28_5 8'hbc
`define STLC_K28_7 8'hfc
`endif

// file: stlc_pkg.sv
// Purpose: Types of the serial transmit link control block
// Assumes: Used with package-qualified names only
// Notes: Constants live in stlc_cfg.svh
package stlc_pkg;
  // ----------------------------------------
  // Link states and carriers
  // ----------------------------------------
  typedef enum logic [2:0] {ST_OFF, ST_CGS, ST_WAIT, ST_ILAS, ST_DATA} stlc_state_t;

  typedef struct packed {
    logic [7:0] stat;
    logic [7:0] c;
    logic [7:0] b;
    logic [7:0] a;
  } stlc_regs_t;

  typedef struct packed {
    logic stb;
    logic [1:0] sel;
    logic [7:0] data;
  } stlc_wr_t;

  typedef struct packed {
    logic [7:0] octet;
    logic is_k;
  } stlc_lane_t;
endpackage : stlc_pkg

// file: stlc_sync.sv
// Purpose: Sync request receiver select and synchroniser
// Assumes: Pins are asynchronous to clk_sys
// Notes: Selection sits before the first flop, so only flop two is read
`timescale 1ns/10ps
`default_nettype none
module stlc_sync (
  input wire logic clk_sys, // System clock
  input wire logic srst, // Sync reset, active high
  input wire logic type_cmos, // 1 selects the single-ended receiver
  input wire logic pin_diff, // Differential receiver level
  input wire logic pin_cmos, // Single-ended receiver level
  output logic sync_lvl // Synchronised pin level
);
  logic raw;
  logic meta_q;

  assign raw = type_cmos ? pin_cmos : pin_diff;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      meta_q <= 1'b1;
      sync_lvl <= 1'b1;
    end else begin
      meta_q <= raw;
      sync_lvl <= meta_q;
    end
  end

  AST_PIN_TYPE: assert property (@(posedge clk_sys) disable iff (srst)
    type_cmos ##1 type_cmos ##1 !srst |-> sync_lvl == $past(pin_cmos, 2))
    else $error("Single-ended sync level not forwarded");
endmodule : stlc_sync
`default_nettype wire

// file: stlc_axil.sv
// Purpose: AXI4-Lite slave for the link control registers
// Assumes: One write and one read in flight; only byte lane 0 is used
// Notes: Unmapped or misaligned addresses answer SLVERR, reads return zero
`include "stlc_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module stlc_axil #(
  parameter int unsigned AW = 16
) (
  input wire logic clk_sys, // System clock
  input wire logic srst, // Sync reset, active high
  input wire logic [AW-1:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [AW-1:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire stlc_pkg::stlc_regs_t regs, // Register read values
  output stlc_pkg::stlc_wr_t wr // Register write strobe
);
  logic [AW-1:0] awaddr_q;
  logic [7:0] wdata_q;
  logic wstrb0_q;
  logic [13:0] widx, ridx;
  logic whit, rhit, wr_go;
  logic [1:0] wsel;
  logic [7:0] rval;

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  assign widx = 14'(awaddr_q >> 2);
  assign ridx = 14'(s_axi_araddr >> 2);
  assign wsel = (widx == `STLC_IDX_CTRL_A) ? `STLC_SEL_A :
                (widx == `STLC_IDX_CTRL_B) ? `STLC_SEL_B : `STLC_SEL_C;
  assign whit = (awaddr_q[1:0] == 2'h0) && ((widx == `STLC_IDX_CTRL_A) ||
                (widx == `STLC_IDX_CTRL_B) || (widx == `STLC_IDX_CTRL_C) ||
                (widx == `STLC_IDX_STATUS));
  assign rhit = (s_axi_araddr[1:0] == 2'h0) && ((ridx == `STLC_IDX_CTRL_A) ||
                (ridx == `STLC_IDX_CTRL_B) || (ridx == `STLC_IDX_CTRL_C) ||
                (ridx == `STLC_IDX_STATUS));
  assign rval = !rhit ? 8'h00 : (ridx == `STLC_IDX_CTRL_A) ? regs.a :
                (ridx == `STLC_IDX_CTRL_B) ? regs.b :
                (ridx == `STLC_IDX_CTRL_C) ? regs.c : regs.stat;
  // Both halves held, no answer pending: commit once
  assign wr_go = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  // Status is read-only, so a write to it is taken and dropped
  assign wr.stb = wr_go && whit && wstrb0_q && (widx != `STLC_IDX_STATUS);
  assign wr.sel = wsel;
  assign wr.data = wdata_q;

  // ----------------------------------------
  // Write channels
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `STLC_RESP_OKAY;
      awaddr_q <= '0;
      wdata_q <= 8'h00;
      wstrb0_q <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_q <= s_axi_wdata[7:0];
        wstrb0_q <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= whit ? `STLC_RESP_OKAY : `STLC_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Read channels
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `STLC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h00_0000, rval};
      s_axi_rresp <= rhit ? `STLC_RESP_OKAY : `STLC_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
endmodule : stlc_axil
`default_nettype wire

// file: stlc_link_ctrl.sv
// Purpose: Transmit link control: sync handling, alignment, test modes
// Assumes: One octet per clk_sys cycle on a single lane
// Notes: Sample input is same-domain logic; sync pins are asynchronous
//
// The AXI4-Lite slave port is this design's own decision.
`include "stlc_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module stlc_link_ctrl #(
  parameter int unsigned AW = 16,
  parameter int unsigned FRAME_OCTETS = 2,
  parameter int unsigned MF_FRAMES = 32
) (
  input wire logic clk_sys, // System clock, 50 MHz
  input wire logic srst, // Sync reset, active high
  input wire logic [AW-1:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [AW-1:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire logic [7:0] sample_in, // Converter sample octet
  input wire logic sync_request_input_diff, // Sync pin, differential, low requests
  input wire logic sync_request_input_cmos, // Sync pin, single-ended, low requests
  output stlc_pkg::stlc_lane_t tx_lane_q, // Lane octet and control flag
  output logic link_clk_en_q // Link clock gate enable
);
  logic [7:0] ctrl_a_q, ctrl_b_q, ctrl_c_q;
  stlc_pkg::stlc_regs_t regs;
  stlc_pkg::stlc_wr_t wr;
  stlc_pkg::stlc_state_t state_q, state_d;
  stlc_pkg::stlc_lane_t lane_d;
  logic [7:0] octet_cnt_q, frame_cnt_q, mf_pos_q, prev_last_q;
  logic [1:0] ilas_mf_q;
  logic prev_ok_q;
  logic sync_lvl, pd, run_rst, standby, stby_sel, long_tpl, lane_sync, frame_align_char_insert_dis;
  logic [1:0] ilas_mode, sync_mode;
  logic ilas_off, ilas_loop, sync_n, pin_req, req;
  logic end_frame, end_mf, lmfc_edge, align_hit, stby_k;
  logic [7:0] tpl_smp, data_smp, align_chr, ilas_oct;
  logic ilas_k;

  // ----------------------------------------
  // Register access
  // ----------------------------------------
  stlc_axil #(.AW(AW)) u_axil (
    .clk_sys(clk_sys),
    .srst(srst),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .regs(regs),
    .wr(wr)
  );

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ctrl_a_q <= `STLC_RST_CTRL_A;
      ctrl_b_q <= `STLC_RST_CTRL_B;
      ctrl_c_q <= `STLC_RST_CTRL_C;
    end else if (wr.stb) begin
      if (wr.sel == `STLC_SEL_A) ctrl_a_q <= wr.data;
      if (wr.sel == `STLC_SEL_B) ctrl_b_q <= wr.data & `STLC_MASK_CTRL_B;
      if (wr.sel == `STLC_SEL_C) ctrl_c_q <= wr.data;
    end
  end

  assign regs.a = ctrl_a_q;
  assign regs.b = ctrl_b_q;
  assign regs.c = ctrl_c_q;
  assign regs.stat = {3'h0, pd, pin_req, state_q};

  // ----------------------------------------
  // Control fields
  // ----------------------------------------
  assign pd = ctrl_a_q[`STLC_A_LINK_PD];
  assign run_rst = srst || pd;
  assign standby = ctrl_c_q[`STLC_C_STANDBY];
  assign stby_sel = ctrl_a_q[`STLC_A_STBY_SEL];
  assign long_tpl = ctrl_a_q[`STLC_A_LONG_TPL];
  assign lane_sync = ctrl_a_q[`STLC_A_LANE_SYNC];
  assign frame_align_char_insert_dis = ctrl_a_q[`STLC_A_FRAME_ALIGN_CHAR_INSERT_DIS];
  assign ilas_mode = ctrl_a_q[`STLC_A_ILAS_HI:`STLC_A_ILAS_LO];
  assign sync_mode = ctrl_b_q[`STLC_B_SYNC_HI:`STLC_B_SYNC_LO];
  assign ilas_off = ilas_mode == `STLC_ILAS_OFF;
  assign ilas_loop = ilas_mode == `STLC_ILAS_LOOP;

  // ----------------------------------------
  // Sync request
  // ----------------------------------------
  stlc_sync u_sync (
    .clk_sys(clk_sys),
    .srst(srst),
    .type_cmos(ctrl_b_q[`STLC_B_SYNC_TYPE]),
    .pin_diff(sync_request_input_diff),
    .pin_cmos(sync_request_input_cmos),
    .sync_lvl(sync_lvl)
  );

  assign sync_n = sync_lvl ^ ctrl_b_q[`STLC_B_SYNC_INV];
  // Receiver asserts low and holds until aligned
  assign pin_req = !sync_n;
  // Unlisted code 01 behaves as normal mode
  assign req = (sync_mode == `STLC_SYNC_FORCE_CGS) ? 1'b1 :
               (sync_mode == `STLC_SYNC_FORCE_DATA) ? 1'b0 : pin_req;

  // ----------------------------------------
  // Frame and multiframe counters
  // ----------------------------------------
  assign end_frame = octet_cnt_q == 8'(FRAME_OCTETS - 1);
  assign end_mf = end_frame && (frame_cnt_q == 8'(MF_FRAMES - 1));
  assign lmfc_edge = (octet_cnt_q == 8'h00) && (frame_cnt_q == 8'h00);

  always_ff @(posedge clk_sys) begin
    if (run_rst) begin
      octet_cnt_q <= 8'h00;
      frame_cnt_q <= 8'h00;
      mf_pos_q <= 8'h00;
    end else begin
      octet_cnt_q <= end_frame ? 8'h00 : octet_cnt_q + 8'h01;
      mf_pos_q <= end_mf ? 8'h00 : mf_pos_q + 8'h01;
      if (end_mf) frame_cnt_q <= 8'h00;
      else if (end_frame) frame_cnt_q <= frame_cnt_q + 8'h01;
    end
  end

  // ----------------------------------------
  // Link state
  // ----------------------------------------
  always_comb begin
    state_d = state_q;
    case (state_q)
      stlc_pkg::ST_OFF: state_d = stlc_pkg::ST_CGS;
      stlc_pkg::ST_CGS: begin
        if (!req) state_d = stlc_pkg::ST_WAIT;
      end
      stlc_pkg::ST_WAIT: begin
        // Switch on the last octet so the sequence opens on the edge
        if (req) state_d = stlc_pkg::ST_CGS;
        else if (end_mf) state_d = ilas_off ? stlc_pkg::ST_DATA : stlc_pkg::ST_ILAS;
      end
      stlc_pkg::ST_ILAS: begin
        if (req) state_d = stlc_pkg::ST_CGS;
        else if (end_mf && ilas_mf_q == `STLC_ILAS_LAST_MF && !ilas_loop) begin
          state_d = stlc_pkg::ST_DATA;
        end
      end
      stlc_pkg::ST_DATA: begin
        if (req) state_d = stlc_pkg::ST_CGS;
      end
      default: state_d = stlc_pkg::ST_OFF;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (run_rst) begin
      state_q <= stlc_pkg::ST_OFF;
      ilas_mf_q <= 2'h0;
    end else begin
      state_q <= state_d;
      if (state_q != stlc_pkg::ST_ILAS) ilas_mf_q <= 2'h0;
      else if (end_mf) ilas_mf_q <= ilas_mf_q + 2'h1;
    end
  end

  // ----------------------------------------
  // Lane data
  // ----------------------------------------
  assign tpl_smp = {frame_cnt_q[3:0], octet_cnt_q[3:0]};
  assign data_smp = long_tpl ? tpl_smp :
                    ((standby && !stby_sel) ? 8'h00 : sample_in);
  assign stby_k = standby && stby_sel;
  // Repeat of last frame octet is replaced by an alignment char
  assign align_hit = !frame_align_char_insert_dis && end_frame && prev_ok_q &&
                     (data_smp == prev_last_q);
  assign align_chr = (lane_sync && end_mf) ? `STLC_K28_3 : `STLC_K28_7;
  assign ilas_k = lmfc_edge || end_mf ||
                  ((ilas_mf_q == 2'h1) && (frame_cnt_q == 8'h00) && (octet_cnt_q == 8'h01));
  assign ilas_oct = lmfc_edge ? `STLC_K28_0 : end_mf ? `STLC_K28_3 :
                    ilas_k ? `STLC_K28_4 : mf_pos_q;

  always_comb begin
    lane_d = '0;
    case (state_q)
      stlc_pkg::ST_CGS, stlc_pkg::ST_WAIT: lane_d = {`STLC_K28_5, 1'b1};
      stlc_pkg::ST_ILAS: lane_d = {ilas_oct, ilas_k};
      stlc_pkg::ST_DATA: lane_d = align_hit ? {align_chr, 1'b1} : {data_smp, 1'b0};
      default: lane_d = '0;
    endcase
    if (stby_k && state_q != stlc_pkg::ST_OFF) lane_d = {`STLC_K28_5, 1'b1};
  end

  always_ff @(posedge clk_sys) begin
    if (run_rst) begin
      tx_lane_q <= '0;
      prev_last_q <= 8'h00;
      prev_ok_q <= 1'b0;
    end else begin
      tx_lane_q <= lane_d;
      if (state_q != stlc_pkg::ST_DATA) prev_ok_q <= 1'b0;
      else if (end_frame) begin
        prev_last_q <= data_smp;
        prev_ok_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) link_clk_en_q <= 1'b0;
    else link_clk_en_q <= !pd;
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  AST_STBY_ZERO: assert property (
    state_q == stlc_pkg::ST_DATA && standby && !stby_sel && !long_tpl && !align_hit && !pd
    |=> tx_lane_q == '0) else $error("Standby sample not zero");
  AST_STBY_CGS: assert property (
    stby_k && state_q != stlc_pkg::ST_OFF && !pd
    |=> tx_lane_q.octet == `STLC_K28_5 && tx_lane_q.is_k) else $error("Standby not K28.5");
  AST_LONG_TPL: assert property (
    state_q == stlc_pkg::ST_DATA && long_tpl && !align_hit && !stby_k && !pd
    |=> tx_lane_q.octet == $past(tpl_smp)) else $error("Test sample missing");
  AST_ALIGN_K287: assert property (
    state_q == stlc_pkg::ST_DATA && align_hit && !(lane_sync && end_mf) && !stby_k && !pd
    |=> tx_lane_q.octet == `STLC_K28_7 && tx_lane_q.is_k) else $error("Expected K28.7");
  AST_ILAS_OFF: assert property (
    state_q == stlc_pkg::ST_WAIT && ilas_off && end_mf && !req && !pd
    |=> state_q == stlc_pkg::ST_DATA) else $error("Sequence not skipped");
  AST_ILAS_LOOP: assert property (
    state_q == stlc_pkg::ST_ILAS && ilas_loop && !req && !pd
    |=> state_q == stlc_pkg::ST_ILAS) else $error("Sequence loop left");
  AST_FRAME_ALIGN_CHAR_INSERT_OFF: assert property (
    frame_align_char_insert_dis && state_q == stlc_pkg::ST_DATA && !stby_k && !pd
    |=> !tx_lane_q.is_k) else $error("Alignment char while disabled");
  AST_CGS_REQ: assert property (
    state_q == stlc_pkg::ST_DATA && req && !pd && !stby_k
    |=> state_q == stlc_pkg::ST_CGS ##1 tx_lane_q.octet == `STLC_K28_5 || pd)
    else $error("Request did not start K28.5");
  AST_PD: assert property (
    pd ##1 pd |=> tx_lane_q == '0 && !link_clk_en_q && state_q == stlc_pkg::ST_OFF)
    else $error("Powered down link active");
  AST_FORCE_CGS: assert property (
    sync_mode == `STLC_SYNC_FORCE_CGS && state_q != stlc_pkg::ST_OFF && !pd
    |=> state_q == stlc_pkg::ST_CGS || pd) else $error("Forced K28.5 not held");
  AST_FORCE_DATA: assert property (
    sync_mode == `STLC_SYNC_FORCE_DATA && state_q == stlc_pkg::ST_CGS && !pd
    |=> state_q == stlc_pkg::ST_WAIT || pd) else $error("Forced data ignored");
  AST_SYNC_INV: assert property (
    sync_mode == 2'h0 && state_q == stlc_pkg::ST_DATA && !pd &&
    (sync_lvl == ctrl_b_q[`STLC_B_SYNC_INV])
    |=> state_q == stlc_pkg::ST_CGS || pd) else $error("Sync polarity wrong");
  AST_ILAS_START: assert property (
    state_q == stlc_pkg::ST_WAIT && !req && !ilas_off && end_mf && !pd
    |=> state_q == stlc_pkg::ST_ILAS && lmfc_edge) else $error("Sequence off the edge");

  COV_ILAS: cover property (state_q == stlc_pkg::ST_WAIT ##1 state_q == stlc_pkg::ST_ILAS);
  COV_DATA: cover property (state_q == stlc_pkg::ST_ILAS ##1 state_q == stlc_pkg::ST_DATA);
  COV_ALIGN: cover property (state_q == stlc_pkg::ST_DATA && align_hit && lane_sync && end_mf);
  COV_REQ: cover property (state_q == stlc_pkg::ST_DATA ##1 state_q == stlc_pkg::ST_CGS);
endmodule : stlc_link_ctrl
`default_nettype wire

// file: stlc_rx_model.sv
// Purpose: Receiver model driving the sync request pins
// Assumes: Request is low on the pin picked by sel_cmos
// Notes: Releases after four K28.5 octets in a row
`timescale 1ns/10ps
`default_nettype none
module stlc_rx_model (
  input wire logic clk_sys, // System clock
  input wire logic srst, // Sync reset
  input wire logic demand, // Pulse: ask for code sync
  input wire logic sel_cmos, // Use single-ended pin
  input wire stlc_pkg::stlc_lane_t lane, // Lane seen
  output logic pin_diff, // Differential pin
  output logic pin_cmos // Single-ended pin
);
  logic req_q;
  logic [1:0] seen_q;
  logic is_cgs;
  assign is_cgs = (lane == {`STLC_K28_5, 1'h1});
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      req_q <= 1'h0;
    end else if (demand) begin
      req_q <= 1'h1;
    end else if (seen_q == 2'h3 && is_cgs) begin
      req_q <= 1'h0;
    end
    seen_q <= (req_q && is_cgs) ? seen_q + 2'h1 : 2'h0;
  end
  // Idle pin stays high so only one receiver can request
  assign pin_diff = sel_cmos | ~req_q;
  assign pin_cmos = ~sel_cmos | ~req_q;
endmodule : stlc_rx_model
`default_nettype wire

// file: tb.sv
// Purpose: Self-checking bench for the link control block
// Assumes: Four frames per multiframe
// Notes: Link checks scan the lane for one octet
`include "stlc_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic clk_sys = 1'h0, srst = 1'h1, demand = 1'h0, sel_cmos = 1'h0, hit;
  logic [15:0] s_axi_awaddr = 16'h0, s_axi_araddr = 16'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h1;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h1, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, link_clk_en_q;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'h1;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [7:0] sample_in = 8'h5a;
  logic sync_request_input_diff, sync_request_input_cmos;
  stlc_pkg::stlc_lane_t tx_lane_q;
  int fail_count = 0, cmp_count = 0;
  localparam logic [15:0] RA = `STLC_IDX_CTRL_A * 4, RB = `STLC_IDX_CTRL_B * 4;
  localparam logic [15:0] RC = `STLC_IDX_CTRL_C * 4;
  localparam logic [8:0] K5 = {`STLC_K28_5, 1'h1}, K0 = {`STLC_K28_0, 1'h1};
  localparam logic [8:0] K7 = {`STLC_K28_7, 1'h1}, K3 = {`STLC_K28_3, 1'h1};
  localparam logic [8:0] S5A = {8'h5a, 1'h0};
  stlc_link_ctrl #(.MF_FRAMES(4)) stlc_link_ctrl_i (.clk_sys, .srst, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sample_in,
    .sync_request_input_diff, .sync_request_input_cmos, .tx_lane_q, .link_clk_en_q);
  stlc_rx_model stlc_rx_model_i (.clk_sys, .srst, .demand, .sel_cmos, .lane(tx_lane_q),
    .pin_diff(sync_request_input_diff), .pin_cmos(sync_request_input_cmos));
  initial forever #10 clk_sys = ~clk_sys;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // Ready signals stay high so back-to-back calls never re-drive them
  task automatic wr(input logic [15:0] a, input logic [7:0] d,
                    input logic [1:0] rsp = `STLC_RESP_OKAY);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    do begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    chk({30'h0, s_axi_bresp}, {30'h0, rsp});
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [7:0] exp, input logic [1:0] rsp);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    chk(s_axi_rdata, {24'h0, exp});
    chk({30'h0, s_axi_rresp}, {30'h0, rsp});
  endtask : rd
  task automatic scan(input logic [8:0] v, input int n, input logic want);
    hit = 1'h0;
    // Sample mid-cycle, then hand back on a rising edge for the next driver
    repeat (n) begin
      @(negedge clk_sys);
      if (tx_lane_q === v) hit = 1'h1;
    end
    @(posedge clk_sys);
    chk({31'h0, hit}, {31'h0, want});
  endtask : scan
  task automatic ask();
    demand <= 1'h1;
    @(posedge clk_sys);
    demand <= 1'h0;
  endtask : ask
  task automatic stop_test();
    $display("Mismatches %0d, comparisons %0d", fail_count, cmp_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : stop_test
  initial begin
    repeat (6000) @(posedge clk_sys);
    fail_count++;
    stop_test();
  end
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (8) @(posedge clk_sys);
    srst <= 1'h0;
    @(posedge clk_sys);
    rd(RA, 8'h14, `STLC_RESP_OKAY);
    rd(RB, 8'h00, `STLC_RESP_OKAY);
    rd(16'h1000, 8'h00, `STLC_RESP_SLVERR);
    wr(16'h1000, 8'hff, `STLC_RESP_SLVERR);
    scan(K7, 150, 1'h1);
    scan(K3, 40, 1'h1);
    wr(RA, 8'h04);
    scan(K3, 40, 1'h0);
    wr(RA, 8'h16);
    scan(K7, 40, 1'h0);
    scan(S5A, 10, 1'h1);
    ask();
    scan(K5, 10, 1'h1);
    scan(K0, 60, 1'h1);
    wr(RA, 8'h12);
    repeat (40) @(posedge clk_sys);
    ask();
    scan(K0, 60, 1'h0);
    wr(RA, 8'h32);
    scan(S5A, 20, 1'h0);
    scan(9'h002, 20, 1'h1);
    wr(RA, 8'h12);
    wr(RC, 8'h01);
    scan(9'h000, 10, 1'h1);
    scan(S5A, 10, 1'h0);
    wr(RA, 8'h92);
    scan(K5, 10, 1'h1);
    wr(RC, 8'h00);
    wr(RA, 8'h12);
    wr(RB, 8'h80);
    scan(K5, 10, 1'h1);
    wr(RB, 8'hc0);
    repeat (20) @(posedge clk_sys);
    ask();
    scan(K5, 20, 1'h0);
    wr(RB, 8'h00);
    repeat (60) @(posedge clk_sys);
    wr(RB, 8'h20);
    scan(K5, 10, 1'h1);
    wr(RB, 8'h00);
    repeat (60) @(posedge clk_sys);
    sel_cmos <= 1'h1;
    ask();
    scan(K5, 20, 1'h0);
    wr(RB, 8'h10);
    scan(K5, 20, 1'h1);
    wr(RA, 8'h1e);
    ask();
    repeat (80) @(posedge clk_sys);
    scan(K0, 10, 1'h1);
    wr(RA, 8'h1f);
    scan(9'h000, 3, 1'h1);
    chk({31'h0, link_clk_en_q}, 32'h0);
    chk({23'h0, tx_lane_q}, 32'h0);
    stop_test();
  end
endmodule : tb
`default_nettype wire
